// ---- design/mac_params.svh ----
// Offsets, field positions and timing constants of the arming control block
`ifndef MAC_PARAMS_SVH
`define MAC_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MAC_ADR_W 8
`define MAC_OFF_MODE 8'h00
`define MAC_OFF_START_CFG 8'h04
`define MAC_OFF_START_WAIT 8'h08
`define MAC_OFF_STOP_ARM_SUBLEVEL_CFG 8'h0C
`define MAC_OFF_STOP_ARM_SUBLEVEL_WAIT 8'h10
`define MAC_OFF_CTRL 8'h14
`define MAC_OFF_STATUS 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MAC_POL_BIT 0
`define MAC_SRC_LSB 1
`define MAC_DCH_LSB 8
`define MAC_CTRL_PRESET 0
`define MAC_CTRL_GO 1
`define MAC_CTRL_ABORT 2
`define MAC_ST_BUSY 0
`define MAC_ST_GATE 1
`define MAC_ST_REJECT 2
`define MAC_ST_DONE 3
`define MAC_ST_STATE_LSB 4
`define MAC_MODE_LAST 5'h18
`define MAC_WAIT_W 32
// ----------------------------------------------------------------
// Default waits, in ns, cycles or events
// ----------------------------------------------------------------
`define MAC_TB_NS 2
`define MAC_HOLD_NS 2
`define MAC_INTERVAL_SAMPLING_NS 10000
`define MAC_TIME_SAMPLING_NS 1000000000
`define MAC_CYCLE_SAMPLING_CYC 32'h0000_0010
`define MAC_EVH_EVT 32'h0000_0001
`define MAC_EDGE_THEN_EVENT_EVT 32'h0000_0001
`define MAC_EVENT_THEN_EVENT_EVT 32'h0000_000A
`endif

// ---- design/mac_pkg.sv ----
// Types shared by the arming control block
`include "mac_params.svh"
package mac_pkg;
  typedef enum logic [4:0] {
    mode_free_running_arm = 5'h00, mode_edge_holdoff = 5'h01, mode_time_holdoff = 5'h02,
    mode_event_holdoff = 5'h03, mode_interval_sampling = 5'h04, mode_time_sampling = 5'h05,
    mode_cycle_sampling = 5'h06, mode_edge_sampling = 5'h07, mode_parity_sampling = 5'h08,
    mode_repetitive_edge = 5'h09, mode_repetitive_edge_parity = 5'h0A,
    mode_random_sampling = 5'h0B, mode_edge_then_interval = 5'h0C, mode_edge_then_time = 5'h0D,
    mode_edge_then_edge = 5'h0E, mode_gated_by_external = 5'h0F, mode_edge_then_cycle = 5'h10,
    mode_edge_then_event = 5'h11, mode_edge_then_parity = 5'h12, mode_edge_then_random = 5'h13,
    mode_time_then_interval = 5'h14, mode_time_then_time = 5'h15,
    mode_event_then_interval = 5'h16, mode_event_then_event = 5'h17,
    mode_operator_triggered = 5'h18
  } mac_mode_e;
  typedef enum logic [1:0] {src_chan_a = 2'h0, src_chan_b = 2'h1, src_ext_arm = 2'h2} mac_src_e;
  typedef enum logic [1:0] {dch_chan_a = 2'h0, dch_chan_b = 2'h1, dch_timebase = 2'h2} mac_dch_e;
  typedef enum logic [3:0] {
    st_idle = 4'b0001, st_edge = 4'b0010, st_hold = 4'b0100, st_run = 4'b1000
  } mac_state_e;
  typedef struct packed {
    logic pol;
    mac_src_e src;
    mac_dch_e count_source_channel;
    logic [`MAC_WAIT_W-1:0] wait_val;
  } mac_stage_s;
  typedef struct packed {
    logic st_edge, st_wait, st_time, st_dch;
    logic sp_edge, sp_time, sp_cycle, sp_event, sp_wait, sp_dch, noncont;
  } mac_caps_s;
endpackage

// ---- design/mac_arming.sv ----
// Arming sequencer with classic Wishbone register slave
//
// Function
// R1 - Edge then count events starts measurement
// R2 - Stop after programmed stop event count
// R3 - Start and stop counts share start edge
// R4 - Reject fields the mode leaves undefined
// R5 - Preset, remote or local key, restores defaults
// R6 - Source A, B or external; A, rising default
// R7 - Timebase usable as cycle count source
// R8 - Per-mode default wait values
// R9 - Two sublevels: start and sample
// R10 - Host sets mode before sublevel fields
// R11 - Defaults shown; stageless modes take nothing
// R12 - Host command lines stay short
// R13 - Start/stop modes take one measurement
// R14 - Time waits are timebase down-counters
// R15 - Mode enum selects active fields
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mac_params.svh"
module mac_arming #(
  parameter int unsigned INTERVAL_TICKS = `MAC_INTERVAL_SAMPLING_NS / `MAC_TB_NS,
  parameter int unsigned TIME_STOP_ARM_SUBLEVEL_TICKS = `MAC_TIME_SAMPLING_NS / `MAC_TB_NS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`MAC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic ext_arm,
  input wire logic timebase_tick,
  input wire logic panel_preset,
  input wire logic local_mode,
  output logic block_arm,
  output logic sample_arm,
  output logic meas_gate,
  output logic acq_busy
);
  localparam int unsigned HOLD_TICKS_RAW = `MAC_HOLD_NS / `MAC_TB_NS;
  localparam int unsigned HOLD_TICKS = (HOLD_TICKS_RAW < 1) ? 1 : HOLD_TICKS_RAW;

  // ----------------------------------------------------------------
  // Mode capability and default tables
  // ----------------------------------------------------------------
  function automatic mac_pkg::mac_caps_s caps_of(input mac_pkg::mac_mode_e m);
    mac_pkg::mac_caps_s c;
    c = '0;
    c.st_edge = !(m inside {mac_pkg::mode_free_running_arm, mac_pkg::mode_interval_sampling,
      mac_pkg::mode_time_sampling, mac_pkg::mode_cycle_sampling, mac_pkg::mode_edge_sampling,
      mac_pkg::mode_parity_sampling, mac_pkg::mode_random_sampling,
      mac_pkg::mode_operator_triggered});
    c.st_time = m inside {mac_pkg::mode_time_holdoff, mac_pkg::mode_time_then_interval,
      mac_pkg::mode_time_then_time};
    c.st_dch = m inside {mac_pkg::mode_event_holdoff, mac_pkg::mode_event_then_interval,
      mac_pkg::mode_event_then_event};
    c.st_wait = c.st_time | c.st_dch;
    c.sp_edge = m inside {mac_pkg::mode_edge_sampling, mac_pkg::mode_edge_then_edge,
      mac_pkg::mode_gated_by_external};
    c.sp_time = m inside {mac_pkg::mode_interval_sampling, mac_pkg::mode_time_sampling,
      mac_pkg::mode_edge_then_interval, mac_pkg::mode_edge_then_time,
      mac_pkg::mode_time_then_interval, mac_pkg::mode_time_then_time,
      mac_pkg::mode_event_then_interval};
    c.sp_cycle = m inside {mac_pkg::mode_cycle_sampling, mac_pkg::mode_edge_then_cycle};
    c.sp_event = m inside {mac_pkg::mode_edge_then_event, mac_pkg::mode_event_then_event};
    c.sp_wait = c.sp_time | c.sp_cycle | c.sp_event;
    c.sp_dch = c.sp_cycle | c.sp_event;
    c.noncont = m inside {mac_pkg::mode_edge_then_time, mac_pkg::mode_edge_then_event,
      mac_pkg::mode_time_then_time, mac_pkg::mode_event_then_event,
      mac_pkg::mode_operator_triggered};
    return c;
  endfunction

  // Channel A, rising edge and the mode's wait are the defaults
  function automatic mac_pkg::mac_stage_s dflt_of(input mac_pkg::mac_mode_e m, input logic stop_arm_sublevel);
    mac_pkg::mac_stage_s s;
    mac_pkg::mac_caps_s c;
    c = caps_of(m);
    s = '0;
    s.src = mac_pkg::src_chan_a; // see R6
    s.count_source_channel = mac_pkg::dch_chan_a;
    if (!stop_arm_sublevel) begin
      if (c.st_time) begin
        s.wait_val = `MAC_WAIT_W'(HOLD_TICKS); // see R8
      end else if (c.st_dch) begin
        s.wait_val = `MAC_EVH_EVT;
      end
    end else if (c.sp_cycle) begin
      s.wait_val = `MAC_CYCLE_SAMPLING_CYC;
    end else if (c.sp_event) begin
      s.wait_val = (m == mac_pkg::mode_event_then_event) ? `MAC_EVENT_THEN_EVENT_EVT : `MAC_EDGE_THEN_EVENT_EVT;
    end else if (m inside {mac_pkg::mode_time_sampling, mac_pkg::mode_edge_then_time,
        mac_pkg::mode_time_then_time}) begin
      s.wait_val = `MAC_WAIT_W'(TIME_STOP_ARM_SUBLEVEL_TICKS);
    end else if (c.sp_time) begin
      s.wait_val = `MAC_WAIT_W'(INTERVAL_TICKS);
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Registers and bus strobes
  // ----------------------------------------------------------------
  mac_pkg::mac_mode_e mode_reg, mode_next;
  mac_pkg::mac_stage_s start_reg, start_next, stop_arm_sublevel_reg, stop_arm_sublevel_next;
  mac_pkg::mac_state_e state_reg, state_next;
  mac_pkg::mac_caps_s caps;
  logic [`MAC_WAIT_W-1:0] hold_cnt_reg, stop_arm_sublevel_cnt_reg, stop_cnt_reg;
  logic [2:0] pin_prev_reg;
  logic [2:0] rise, fall;
  logic reject_reg, done_reg, rej_now;
  logic wb_req, wb_wr, go_cmd, abort_cmd, preset_now, w1c_reject, w1c_done;
  logic st_hit, sp_hit, hold_dec, stop_arm_sublevel_dec, stop_evt, stop_reached;
  logic fire_block, fire_stop_arm_sublevel, end_meas;

  assign caps = caps_of(mode_reg); // see R15
  assign wb_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where ack is seen high
  assign wb_wr = wb_req & wb_we_i & wb_ack_o;
  assign go_cmd = wb_wr && wb_adr_i == `MAC_OFF_CTRL && wb_sel_i[0] && wb_dat_i[`MAC_CTRL_GO];
  assign abort_cmd = wb_wr && wb_adr_i == `MAC_OFF_CTRL && wb_sel_i[0]
    && wb_dat_i[`MAC_CTRL_ABORT];
  assign preset_now = (wb_wr && wb_adr_i == `MAC_OFF_CTRL && wb_sel_i[0]
    && wb_dat_i[`MAC_CTRL_PRESET]) || (panel_preset && local_mode); // see R5
  assign w1c_reject = wb_wr && wb_adr_i == `MAC_OFF_STATUS && wb_sel_i[0]
    && wb_dat_i[`MAC_ST_REJECT];
  assign w1c_done = wb_wr && wb_adr_i == `MAC_OFF_STATUS && wb_sel_i[0]
    && wb_dat_i[`MAC_ST_DONE];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  // ----------------------------------------------------------------
  // Sublevel write decode
  // ----------------------------------------------------------------
  // Config lanes are checked on their own, wait writes as a whole; a refused lane keeps its old field
  always_comb begin
    mode_next = mode_reg;
    start_next = start_reg;
    stop_arm_sublevel_next = stop_arm_sublevel_reg;
    rej_now = 1'b0;
    if (wb_wr) begin
      unique case (wb_adr_i)
        `MAC_OFF_MODE: begin
          if (wb_sel_i[0]) begin
            if (wb_dat_i[4:0] <= `MAC_MODE_LAST) begin
              mode_next = mac_pkg::mac_mode_e'(wb_dat_i[4:0]);
              // Mode change reloads both sublevels, so it must come first
              start_next = dflt_of(mode_next, 1'b0); // see R10 see R11
              stop_arm_sublevel_next = dflt_of(mode_next, 1'b1);
            end else begin
              rej_now = 1'b1;
            end
          end
        end
        `MAC_OFF_START_CFG: begin // see R9
          if (wb_sel_i[0]) begin
            if (caps.st_edge && wb_dat_i[`MAC_SRC_LSB+:2] != 2'h3) begin // see R4 see R6
              start_next.pol = wb_dat_i[`MAC_POL_BIT];
              start_next.src = mac_pkg::mac_src_e'(wb_dat_i[`MAC_SRC_LSB+:2]);
            end else begin
              rej_now = 1'b1;
            end
          end
          if (wb_sel_i[1]) begin
            if (caps.st_dch && !wb_dat_i[`MAC_DCH_LSB+1]) begin // see R4
              start_next.count_source_channel = mac_pkg::mac_dch_e'(wb_dat_i[`MAC_DCH_LSB+:2]);
            end else begin
              rej_now = 1'b1;
            end
          end
        end
        `MAC_OFF_STOP_ARM_SUBLEVEL_CFG: begin // see R9
          if (wb_sel_i[0]) begin
            if (caps.sp_edge && wb_dat_i[`MAC_SRC_LSB+:2] != 2'h3) begin // see R4
              stop_arm_sublevel_next.pol = wb_dat_i[`MAC_POL_BIT];
              stop_arm_sublevel_next.src = mac_pkg::mac_src_e'(wb_dat_i[`MAC_SRC_LSB+:2]);
            end else begin
              rej_now = 1'b1;
            end
          end
          if (wb_sel_i[1]) begin
            // Timebase only counts in cycle sampling and edge then cycle
            if (caps.sp_dch && wb_dat_i[`MAC_DCH_LSB+:2] != 2'h3
                && (caps.sp_cycle || !wb_dat_i[`MAC_DCH_LSB+1])) begin // see R4 see R7
              stop_arm_sublevel_next.count_source_channel = mac_pkg::mac_dch_e'(wb_dat_i[`MAC_DCH_LSB+:2]);
            end else begin
              rej_now = 1'b1;
            end
          end
        end
        `MAC_OFF_START_WAIT, `MAC_OFF_STOP_ARM_SUBLEVEL_WAIT: begin
          if (wb_sel_i != 4'h0) begin
            if (wb_adr_i == `MAC_OFF_START_WAIT ? caps.st_wait : caps.sp_wait) begin // see R4
              for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                  if (wb_adr_i == `MAC_OFF_START_WAIT) begin
                    start_next.wait_val[i*8+:8] = wb_dat_i[i*8+:8];
                  end else begin
                    stop_arm_sublevel_next.wait_val[i*8+:8] = wb_dat_i[i*8+:8];
                  end
                end
              end
            end else begin
              rej_now = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_reg <= mac_pkg::mode_free_running_arm;
      start_reg <= '0;
      stop_arm_sublevel_reg <= '0;
    end else if (preset_now) begin
      mode_reg <= mac_pkg::mode_free_running_arm; // see R5
      start_reg <= dflt_of(mac_pkg::mode_free_running_arm, 1'b0);
      stop_arm_sublevel_reg <= dflt_of(mac_pkg::mode_free_running_arm, 1'b1);
    end else begin
      mode_reg <= mode_next;
      start_reg <= start_next;
      stop_arm_sublevel_reg <= stop_arm_sublevel_next;
    end
  end

  // Set wins over write-one-clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reject_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      reject_reg <= rej_now | (reject_reg & ~w1c_reject); // see R4
      done_reg <= end_meas | (done_reg & ~w1c_done);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      unique case (wb_adr_i)
        `MAC_OFF_MODE: wb_dat_o <= {27'h0, mode_reg};
        `MAC_OFF_START_CFG: wb_dat_o <= {22'h0, start_reg.count_source_channel, 5'h0, start_reg.src,
          start_reg.pol};
        `MAC_OFF_START_WAIT: wb_dat_o <= start_reg.wait_val;
        `MAC_OFF_STOP_ARM_SUBLEVEL_CFG: wb_dat_o <= {22'h0, stop_arm_sublevel_reg.count_source_channel, 5'h0, stop_arm_sublevel_reg.src, stop_arm_sublevel_reg.pol};
        `MAC_OFF_STOP_ARM_SUBLEVEL_WAIT: wb_dat_o <= stop_arm_sublevel_reg.wait_val;
        `MAC_OFF_STATUS: wb_dat_o <= {24'h0, state_reg, done_reg, reject_reg, meas_gate,
          acq_busy};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input edges and count sources
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_prev_reg <= 3'h0;
    end else begin
      pin_prev_reg <= {ext_arm, chan_b, chan_a};
    end
  end

  assign rise = {ext_arm, chan_b, chan_a} & ~pin_prev_reg;
  assign fall = ~{ext_arm, chan_b, chan_a} & pin_prev_reg;

  function automatic logic edge_of(input mac_pkg::mac_stage_s s, input logic [2:0] r,
      input logic [2:0] f);
    logic [3:0] v;
    v = s.pol ? {1'b0, f} : {1'b0, r};
    return v[s.src];
  endfunction

  // Event counting uses rising edges of the count source
  function automatic logic count_of(input mac_pkg::mac_dch_e d, input logic [2:0] r,
      input logic tick);
    return (d == mac_pkg::dch_timebase) ? tick : (d == mac_pkg::dch_chan_b) ? r[1] : r[0];
  endfunction

  assign st_hit = edge_of(start_reg, rise, fall);
  assign sp_hit = edge_of(stop_arm_sublevel_reg, rise, fall);
  assign hold_dec = caps.st_time ? timebase_tick
    : count_of(start_reg.count_source_channel, rise, timebase_tick); // see R1 see R14
  assign stop_arm_sublevel_dec = caps.sp_cycle ? count_of(stop_arm_sublevel_reg.count_source_channel, rise, timebase_tick)
    : timebase_tick; // see R7 see R14
  assign stop_evt = count_of(stop_arm_sublevel_reg.count_source_channel, rise, timebase_tick);
  assign stop_reached = (stop_cnt_reg + `MAC_WAIT_W'(stop_evt)) >= stop_arm_sublevel_reg.wait_val; // see R2

  // ----------------------------------------------------------------
  // Arming sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    fire_block = 1'b0;
    fire_stop_arm_sublevel = 1'b0;
    end_meas = 1'b0;
    unique case (state_reg)
      mac_pkg::st_idle: begin
        if (go_cmd) begin
          if (caps.st_edge) begin
            state_next = mac_pkg::st_edge;
          end else begin
            fire_block = 1'b1;
            state_next = mac_pkg::st_run;
          end
        end
      end
      mac_pkg::st_edge: begin
        if (st_hit) begin // see R1
          if (caps.st_wait) begin
            state_next = mac_pkg::st_hold;
          end else begin
            fire_block = 1'b1;
            state_next = mac_pkg::st_run;
          end
        end
      end
      mac_pkg::st_hold: begin
        if (hold_dec && hold_cnt_reg <= `MAC_WAIT_W'(1)) begin // see R1 see R14
          fire_block = 1'b1;
          state_next = mac_pkg::st_run;
        end
      end
      mac_pkg::st_run: begin
        if (caps.sp_event) begin
          end_meas = stop_reached; // see R2
        end else if (caps.sp_time || caps.sp_cycle) begin
          if (stop_arm_sublevel_dec && stop_arm_sublevel_cnt_reg <= `MAC_WAIT_W'(1)) begin
            fire_stop_arm_sublevel = 1'b1;
            end_meas = caps.noncont; // see R13
          end
        end else if (caps.sp_edge) begin
          fire_stop_arm_sublevel = sp_hit;
        end else begin
          // Stageless operator mode holds the gate until abort
          fire_stop_arm_sublevel = !caps.noncont;
        end
        if (end_meas) begin
          state_next = mac_pkg::st_idle;
        end
      end
      default: state_next = mac_pkg::st_idle;
    endcase
    if (abort_cmd || preset_now) begin
      state_next = mac_pkg::st_idle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= mac_pkg::st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hold_cnt_reg <= '0;
      stop_arm_sublevel_cnt_reg <= '0;
      stop_cnt_reg <= '0;
    end else begin
      if (state_reg == mac_pkg::st_edge && st_hit) begin
        hold_cnt_reg <= start_reg.wait_val;
        stop_cnt_reg <= '0; // see R3
      end else begin
        if (hold_dec && hold_cnt_reg != '0) begin
          hold_cnt_reg <= hold_cnt_reg - `MAC_WAIT_W'(1);
        end
        if (stop_evt && !(state_reg == mac_pkg::st_idle)) begin
          stop_cnt_reg <= stop_cnt_reg + `MAC_WAIT_W'(1); // see R3
        end
      end
      if (fire_block || fire_stop_arm_sublevel) begin
        stop_arm_sublevel_cnt_reg <= stop_arm_sublevel_reg.wait_val;
      end else if (stop_arm_sublevel_dec && stop_arm_sublevel_cnt_reg != '0) begin
        stop_arm_sublevel_cnt_reg <= stop_arm_sublevel_cnt_reg - `MAC_WAIT_W'(1);
      end
    end
  end

  // One measurement per block in start/stop modes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      block_arm <= 1'b0;
      sample_arm <= 1'b0;
      meas_gate <= 1'b0;
      acq_busy <= 1'b0;
    end else begin
      block_arm <= fire_block;
      sample_arm <= fire_stop_arm_sublevel;
      acq_busy <= state_next != mac_pkg::st_idle;
      if (end_meas || abort_cmd || preset_now) begin
        meas_gate <= 1'b0; // see R13
      end else if (fire_block && caps.noncont) begin
        meas_gate <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence edge_seen_s;
    state_reg == mac_pkg::st_edge && st_hit && caps.st_wait && !abort_cmd && !preset_now;
  endsequence
  sequence hold_done_s;
    state_reg == mac_pkg::st_hold && hold_dec && hold_cnt_reg <= `MAC_WAIT_W'(1)
      && !abort_cmd && !preset_now;
  endsequence

  holdoff_entry_a: assert property (edge_seen_s |=> state_reg == mac_pkg::st_hold // see R1
    && hold_cnt_reg == $past(start_reg.wait_val) && stop_cnt_reg == '0) // see R3
    else $error("holdoff not loaded at start edge");
  holdoff_end_a: assert property (hold_done_s // see R1
    |=> block_arm && state_reg == mac_pkg::st_run)
    else $error("block arm missing after holdoff count");
  stop_count_a: assert property (state_reg == mac_pkg::st_run && caps.sp_event // see R2
    && stop_reached && !abort_cmd && !preset_now
    |=> state_reg == mac_pkg::st_idle && !meas_gate && done_reg)
    else $error("measurement did not end at stop count");
  reject_flag_a: assert property (rej_now && !preset_now |=> reject_reg // see R4
    && mode_reg == $past(mode_reg)) else $error("refused write not flagged");
  preset_dflt_a: assert property (preset_now // see R5
    |=> mode_reg == mac_pkg::mode_free_running_arm
    && start_reg.src == mac_pkg::src_chan_a && !start_reg.pol && state_reg == mac_pkg::st_idle)
    else $error("preset did not restore defaults");
  mode_dflt_a: assert property (wb_wr && wb_adr_i == `MAC_OFF_MODE && wb_sel_i[0] // see R8
    && !preset_now && wb_dat_i[4:0] == 5'h04
    |=> stop_arm_sublevel_reg.wait_val == `MAC_WAIT_W'(INTERVAL_TICKS))
    else $error("interval default wait wrong");
  osc_count_a: assert property (state_reg == mac_pkg::st_run && caps.sp_cycle // see R7
    && !fire_stop_arm_sublevel && stop_arm_sublevel_reg.count_source_channel == mac_pkg::dch_timebase && timebase_tick
    && stop_arm_sublevel_cnt_reg > `MAC_WAIT_W'(1)
    |=> stop_arm_sublevel_cnt_reg == $past(stop_arm_sublevel_cnt_reg) - `MAC_WAIT_W'(1))
    else $error("timebase did not step cycle count");
  single_meas_a: assert property ($fell(meas_gate) |-> state_reg == mac_pkg::st_idle // see R13
    ##1 !meas_gate [*2]) else $error("second measurement in start/stop block");
  ack_pulse_a: assert property (wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) // single-cycle Wishbone ack
    else $error("bus answer not a single cycle");
endmodule

// ---- dv/mac_host.sv ----
// Host controller model: classic Wishbone master for the arming block
`timescale 1ns/1ps
module mac_host (
  input wire logic core_clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic [7:0] adr,
  output logic [31:0] wdat,
  output logic [3:0] sel,
  output logic we,
  output logic cyc,
  output logic stb
);
  initial begin
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
  end
  // One request, held until ack is sampled; idle data is inverted, not left stale
  // Each setting goes as one bus word, well inside the line limit
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // Only the bench timeout ends a wait for ack
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    wdat <= ~d;
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the arming sequencer
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rst_b = 1'b0, chan_a = 1'b0, chan_b = 1'b0, ext_arm = 1'b0;
  logic timebase_tick = 1'b0, panel_preset = 1'b0, local_mode = 1'b0;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic we, cyc, stb, ack, block_arm, sample_arm, meas_gate, acq_busy;
  int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
  always #25 core_clk = ~core_clk;
  mac_arming #(.INTERVAL_TICKS(20), .TIME_STOP_ARM_SUBLEVEL_TICKS(50)) dut (.core_clk(core_clk),
    .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .chan_a(chan_a),
    .chan_b(chan_b), .ext_arm(ext_arm), .timebase_tick(timebase_tick),
    .panel_preset(panel_preset), .local_mode(local_mode), .block_arm(block_arm),
    .sample_arm(sample_arm), .meas_gate(meas_gate), .acq_busy(acq_busy));
  mac_host u_host (.core_clk(core_clk), .ack(ack), .rdat(rdat), .adr(adr), .wdat(wdat),
    .sel(sel), .we(we), .cyc(cyc), .stb(stb));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask
  task automatic pulse_b(input int n);
    repeat (n) begin
      @(posedge core_clk) chan_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      chan_b <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge core_clk) timebase_tick <= 1'b1;
      @(posedge core_clk) timebase_tick <= 1'b0;
    end
    @(negedge core_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    wr(8'h14, 32'h0000_0001);
    wr(8'h00, 32'h0000_0017);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0001);
    rd_chk(8'h10, 32'h0000_000A);
    rd_chk(8'h40, 32'h0000_0000);
    wr(8'h04, 32'h0000_0003);
    rd_chk(8'h04, 32'h0000_0003);
    @(posedge core_clk) local_mode <= 1'b1;
    panel_preset <= 1'b1;
    @(posedge core_clk) panel_preset <= 1'b0;
    local_mode <= 1'b0;
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0004);
    rd_chk(8'h10, 32'h0000_0014);
    $display("test defaults done");
  endtask
  task automatic t_reject;
    wr(8'h00, 32'h0000_0006);
    wr(8'h04, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0000);
    check(32'(dut.wb_dat_o[2]), 32'h0);
    u_host.xfer(1'b0, 8'h18, 32'h0, q);
    check(32'(q[2]), 32'h1);
    wr(8'h18, 32'h0000_0004);
    wr(8'h00, 32'h0000_0019);
    rd_chk(8'h00, 32'h0000_0006);
    wr(8'h18, 32'h0000_0004);
    wr(8'h0C, 32'h0000_0200);
    rd_chk(8'h0C, 32'h0000_0200);
    wr(8'h14, 32'h0000_0002);
    @(negedge core_clk) check(32'(block_arm), 32'h1);
    tick_n(15);
    check(32'(sample_arm), 32'h0);
    tick_n(1);
    check(32'(sample_arm), 32'h1);
    wr(8'h14, 32'h0000_0004);
    rd_chk(8'h18, 32'h0000_0014);
    $display("test reject done");
  endtask
  task automatic t_event_run;
    wr(8'h00, 32'h0000_0017);
    wr(8'h04, 32'h0000_0100);
    wr(8'h08, 32'h0000_0005);
    wr(8'h0C, 32'h0000_0100);
    wr(8'h10, 32'h0000_000F);
    rd_chk(8'h18, 32'h0000_0014);
    wr(8'h18, 32'h0000_0004);
    wr(8'h14, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    chan_a <= 1'b1;
    pulse_b(4);
    check(32'(meas_gate), 32'h0);
    pulse_b(1);
    check(32'(meas_gate), 32'h1);
    pulse_b(9);
    check(32'(meas_gate), 32'h1);
    pulse_b(1);
    check(32'(meas_gate), 32'h0);
    check(32'(acq_busy), 32'h0);
    rd_chk(8'h18, 32'h0000_0018);
    chan_a <= 1'b0;
    $display("test event run done");
  endtask
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_defaults();
    t_reject();
    t_event_run();
    stop_test();
  end
endmodule
